// File: src/carry_sub_alu.sv
/*
 Execution datapath for subtract-carry (accumulator or memory), memory
 increment, memory decrement and memory clear, with the four arithmetic
 flags, the accumulator and a Wishbone classic register slave.
 Assumes one clock domain shared with the decoder and a data memory that
 returns read data one clock after a read strobe.
*/
// The implementer's own choices: the Wishbone interface to the registers and the address map.
`include "carry_sub_alu_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module carry_sub_alu
  import carry_sub_alu_pkg::*;
#(
  parameter int MEM_ADR_W = 8
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  // Decoder request
  input wire logic cmdValid,
  input wire logic [2:0] cmdOp,
  input wire logic [MEM_ADR_W-1:0] cmdAddr,
  output logic cmdReady,
  output logic cmdDone,
  // Data memory
  output logic memRdEn,
  output logic memWrEn,
  output logic [MEM_ADR_W-1:0] memAddr,
  output logic [7:0] memWrData,
  input wire logic [7:0] memRdData,
  // Core state
  output logic [7:0] accOut,
  output logic zeroFlag,
  output logic borrowBit,
  output logic half_borrow_bit,
  output logic signed_range_error_flag,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [`ALU_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);

  // ************************************************************
  // Declarations
  // ************************************************************
  // Sequencer and operand registers
  aluState_t state_ff;
  aluState_t nxt_state;
  aluOp_t op_ff;
  logic [MEM_ADR_W-1:0] addr_ff;
  logic [7:0] acc_ff;
  logic [`FLAG_W-1:0] flags_ff;
  logic enable_ff;
  logic [7:0] doneCnt_ff;

  // Registered outputs and bus state
  logic memRdEn_ff;
  logic memWrEn_ff;
  logic [7:0] memWrData_ff;
  logic done_ff;
  logic ack_ff;
  logic [31:0] rdData_ff;

  // Combinational decode and arithmetic
  logic take;
  logic busWrite;
  logic busRead;
  logic [7:0] opnd;
  logic [7:0] subtr;
  logic isAdd;
  logic [8:0] wide;
  logic [4:0] nib;
  logic [7:0] res;
  logic [`FLAG_W-1:0] newFlags;
  logic calcDone;

  // ************************************************************
  // Request acceptance and sequencing
  // ************************************************************
  // Combinational ready lets the decoder see a refusal in the same cycle
  assign cmdReady = (state_ff == ST_IDLE) && enable_ff;
  assign take = cmdValid && cmdReady;
  assign calcDone = (state_ff == ST_CALC);

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (take) begin
          // Accumulator op reads no memory, so it skips the fetch cycle
          if (aluOp_t'(cmdOp) == OP_SUBC_ACC) begin
            nxt_state = ST_CALC;
          end else begin
            nxt_state = ST_FETCH;
          end
        end
      end
      // Every state but idle lasts exactly one cycle
      ST_FETCH: nxt_state = ST_CALC;
      ST_CALC: nxt_state = (op_ff == OP_SUBC_ACC) ? ST_IDLE : ST_WRITE;
      ST_WRITE: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Operands are captured at take; memAddr holds them until the next take
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      op_ff <= OP_SUBC_ACC;
      addr_ff <= '0;
    end else if (take) begin
      op_ff <= aluOp_t'(cmdOp);
      addr_ff <= cmdAddr;
    end
  end

  // ************************************************************
  // Arithmetic
  // ************************************************************
  always_comb begin
    opnd = (op_ff == OP_SUBC_ACC) ? acc_ff : memRdData;
    // Increment is the only adding op; its carry-out lands in the borrow bit
    isAdd = (op_ff == OP_INC_MEM);
    unique case (op_ff)
      OP_SUBC_ACC, OP_SUBC_MEM: subtr = {7'h00, flags_ff[`FLAG_BORROW]};
      OP_INC_MEM, OP_DEC_MEM: subtr = 8'h01;
      default: subtr = 8'h00;
    endcase
    // Nibble path yields the half-borrow or half-carry out of bit 3
    if (isAdd) begin
      wide = {1'b0, opnd} + {1'b0, subtr};
      nib = {1'b0, opnd[3:0]} + {1'b0, subtr[3:0]};
    end else begin
      wide = {1'b0, opnd} - {1'b0, subtr};
      nib = {1'b0, opnd[3:0]} - {1'b0, subtr[3:0]};
    end
    res = (op_ff == OP_CLR_MEM) ? 8'h00 : wide[7:0];
    // Zero tests the raw result; clear never loads the flags
    newFlags[`FLAG_ZERO] = (wide[7:0] == 8'h00);
    newFlags[`FLAG_BORROW] = wide[8];
    newFlags[`FLAG_HALF] = nib[4];
    // Overflow: operand signs alike for add, unlike for subtract, result sign flipped
    newFlags[`FLAG_OVF] = (isAdd ? ~(opnd[7] ^ subtr[7]) : (opnd[7] ^ subtr[7]))
      & (opnd[7] ^ wide[7]);
  end

  // ************************************************************
  // Bus decode
  // ************************************************************
  // A strobe held through its ack cycle starts no second access
  assign busWrite = wb_cyc_i && wb_stb_i && wb_we_i && !ack_ff;
  assign busRead = wb_cyc_i && wb_stb_i && !wb_we_i && !ack_ff;

  // ************************************************************
  // Accumulator and flags
  // ************************************************************

  // Datapath result wins over a bus write in the same cycle
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      acc_ff <= `RST_ACC;
    end else if (calcDone && op_ff == OP_SUBC_ACC) begin
      acc_ff <= res;
    end else if (busWrite && wb_adr_i == `ALU_OFS_ACC && wb_sel_i[0]) begin
      acc_ff <= wb_dat_i[7:0];
    end
  end

  // Clear leaves the flags as they were
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      flags_ff <= `RST_FLAGS;
    end else if (calcDone && op_ff != OP_CLR_MEM) begin
      flags_ff <= newFlags;
    end else if (busWrite && wb_adr_i == `ALU_OFS_FLAGS && wb_sel_i[0]) begin
      flags_ff <= wb_dat_i[`FLAG_W-1:0];
    end
  end

  // ************************************************************
  // Data memory port
  // ************************************************************
  // Read strobe stands in the fetch cycle; data must follow one cycle later
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      memRdEn_ff <= 1'b0;
    end else begin
      memRdEn_ff <= take && aluOp_t'(cmdOp) != OP_SUBC_ACC;
    end
  end

  // Write strobe, write data and done all stand in the write cycle
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      memWrEn_ff <= 1'b0;
      memWrData_ff <= 8'h00;
    end else begin
      memWrEn_ff <= calcDone && op_ff != OP_SUBC_ACC;
      if (calcDone && op_ff != OP_SUBC_ACC) begin
        memWrData_ff <= res;
      end
    end
  end

  // ************************************************************
  // Completion
  // ************************************************************
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      done_ff <= 1'b0;
    end else begin
      done_ff <= calcDone;
    end
  end

  // Counts every finished op, clear included; wraps at 8 bits
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      doneCnt_ff <= `RST_CNT;
    end else if (calcDone) begin
      doneCnt_ff <= doneCnt_ff + 8'h01;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign memRdEn = memRdEn_ff;
  assign memWrEn = memWrEn_ff;
  assign memAddr = addr_ff;
  assign memWrData = memWrData_ff;
  assign cmdDone = done_ff;
  assign accOut = acc_ff;
  assign zeroFlag = flags_ff[`FLAG_ZERO];
  assign borrowBit = flags_ff[`FLAG_BORROW];
  assign half_borrow_bit = flags_ff[`FLAG_HALF];
  assign signed_range_error_flag = flags_ff[`FLAG_OVF];

  // ************************************************************
  // Wishbone slave
  // ************************************************************
  // Disabling holds off new takes only; an op in flight still finishes
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      enable_ff <= `RST_CTRL_EN;
    end else if (busWrite && wb_adr_i == `ALU_OFS_CTRL && wb_sel_i[0]) begin
      enable_ff <= wb_dat_i[`CTRL_EN_BIT];
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= wb_cyc_i && wb_stb_i && !ack_ff;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    // Read data is taken at the access edge and stands through the ack cycle
    // Unmapped offsets read zero; writes to them are dropped
    if (!reset_n) begin
      rdData_ff <= 32'h0000_0000;
    end else if (busRead) begin
      rdData_ff <= 32'h0000_0000;
      unique case (wb_adr_i)
        `ALU_OFS_ACC: rdData_ff[7:0] <= acc_ff;
        `ALU_OFS_FLAGS: rdData_ff[`FLAG_W-1:0] <= flags_ff;
        `ALU_OFS_CTRL: rdData_ff[`CTRL_EN_BIT] <= enable_ff;
        `ALU_OFS_STATUS: begin
          rdData_ff[`STAT_BUSY_BIT] <= (state_ff != ST_IDLE);
          rdData_ff[`STAT_CNT_MSB:`STAT_CNT_LSB] <= doneCnt_ff;
        end
        default: rdData_ff <= 32'h0000_0000;
      endcase
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdData_ff;

endmodule

`default_nettype wire

// File: src/carry_sub_alu_defines.svh
/*
 Register offsets, flag bit positions and reset values of the carry
 subtract / increment / decrement / clear datapath.
 Assumes inclusion by bare name from the datapath module and the testbench.
*/
`ifndef CARRY_SUB_ALU_DEFINES_SVH
`define CARRY_SUB_ALU_DEFINES_SVH

// ************************************************************
// Register byte offsets (Wishbone, one 32-bit word each)
// ************************************************************
`define ALU_ADR_W 4
`define ALU_OFS_ACC 4'h0
`define ALU_OFS_FLAGS 4'h4
`define ALU_OFS_CTRL 4'h8
`define ALU_OFS_STATUS 4'hC

// ************************************************************
// Flag register fields
// ************************************************************
`define FLAG_ZERO 0
`define FLAG_BORROW 1
`define FLAG_HALF 2
`define FLAG_OVF 3
`define FLAG_W 4

// ************************************************************
// Control and status fields
// ************************************************************
`define CTRL_EN_BIT 0
`define STAT_BUSY_BIT 0
`define STAT_CNT_LSB 8
`define STAT_CNT_MSB 15

// ************************************************************
// Reset values
// ************************************************************
`define RST_ACC 8'h00
`define RST_FLAGS 4'h0
`define RST_CTRL_EN 1'b1
`define RST_CNT 8'h00

`endif

// File: src/carry_sub_alu_pkg.sv
/*
 Types shared by the datapath and its bench: operation codes and
 sequencer states.
 Assumes carry_sub_alu_defines.svh is reachable on the include path.
*/
package carry_sub_alu_pkg;

  // Operation selected by the instruction decoder
  typedef enum logic [2:0] {
    OP_SUBC_ACC = 3'h0,
    OP_SUBC_MEM = 3'h1,
    OP_INC_MEM = 3'h2,
    OP_DEC_MEM = 3'h3,
    OP_CLR_MEM = 3'h4
  } aluOp_t;

  // Gray along idle -> fetch -> calc -> write -> idle
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FETCH = 2'b01,
    ST_CALC = 2'b11,
    ST_WRITE = 2'b10
  } aluState_t;

endpackage

// File: bench/carry_sub_alu_assertions.sv
/*
 Checker for the command and data-memory ports of carry_sub_alu.
 Assumes binding to every carry_sub_alu instance, single clock domain.
*/
`timescale 1ns/100ps
`default_nettype none
module carry_sub_alu_assertions
  import carry_sub_alu_pkg::*;
#(
  parameter int MEM_ADR_W = 8
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic cmdValid,
  input wire logic [2:0] cmdOp,
  input wire logic [MEM_ADR_W-1:0] cmdAddr,
  input wire logic cmdReady,
  input wire logic cmdDone,
  input wire logic memRdEn,
  input wire logic memWrEn,
  input wire logic [MEM_ADR_W-1:0] memAddr,
  input wire logic [7:0] memWrData,
  input wire logic [7:0] memRdData,
  input wire logic [7:0] accOut,
  input wire logic zeroFlag,
  input wire logic borrowBit,
  input wire logic signed_range_error_flag
);
  // ************************************************************
  // Command timing and results
  // ************************************************************
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  wire take = cmdValid && cmdReady;
  wire memTake = take && cmdOp != OP_SUBC_ACC;

  a_acc_done_latency: assert property (take && cmdOp == OP_SUBC_ACC |-> ##2 cmdDone)
    else $error("acc op done late");
  a_acc_subc_value: assert property (take && cmdOp == OP_SUBC_ACC |->
    ##2 accOut == $past(accOut, 2) - $past(borrowBit, 2)) else $error("acc result wrong");
  a_mem_read_addr: assert property (memTake |=> memRdEn && memAddr == $past(cmdAddr))
    else $error("memory read missing");
  a_mem_write_done: assert property (memTake |-> ##3 memWrEn && cmdDone)
    else $error("memory write missing");
  a_subc_mem_value: assert property (take && cmdOp == OP_SUBC_MEM |->
    ##3 memWrData == $past(memRdData) - $past(borrowBit)) else $error("subc mem wrong");
  a_inc_mem_value: assert property (take && cmdOp == OP_INC_MEM |->
    ##3 memWrData == $past(memRdData) + 8'h01) else $error("inc wrong");
  a_dec_range_error: assert property (take && cmdOp == OP_DEC_MEM |-> ##3
    memWrData == $past(memRdData) - 8'h01
    && signed_range_error_flag == ($past(memRdData) == 8'h80)) else $error("dec wrong");
  a_clear_to_zero: assert property (take && cmdOp == OP_CLR_MEM |->
    ##3 memWrData == 8'h00 && $stable(zeroFlag)) else $error("clear wrong");
  a_zero_on_null: assert property (memTake && cmdOp != OP_CLR_MEM |->
    ##3 zeroFlag == (memWrData == 8'h00)) else $error("zero flag wrong");
  a_done_one_cycle: assert property (cmdDone |=> !cmdDone)
    else $error("done too long");

  c_acc_op: cover property (take && cmdOp == OP_SUBC_ACC);
  c_mem_write: cover property (memWrEn && cmdDone);
  c_refused: cover property (cmdValid && !cmdReady);
endmodule

bind carry_sub_alu carry_sub_alu_assertions #(.MEM_ADR_W(MEM_ADR_W))
  carry_sub_alu_assertions_inst (
  .clk_sys, .reset_n, .cmdValid, .cmdOp, .cmdAddr, .cmdReady, .cmdDone, .memRdEn, .memWrEn,
  .memAddr, .memWrData, .memRdData, .accOut, .zeroFlag, .borrowBit, .signed_range_error_flag);
`default_nettype wire

// File: bench/data_mem_model.sv
/*
 Data memory seen by the datapath: one-cycle read latency.
 Assumes the bench preloads and inspects mem directly.
*/
`timescale 1ns/100ps
`default_nettype none
module data_mem_model #(
  parameter int AW = 8
) (
  input wire logic clk_sys,
  input wire logic rdEn,
  input wire logic wrEn,
  input wire logic [AW-1:0] addr,
  input wire logic [7:0] wrData,
  output logic [7:0] rdData
);
  logic [7:0] mem [2**AW];
  initial rdData = 8'h00;
  // Outside a read cycle the bus toggles so stale data never looks valid
  always @(posedge clk_sys) begin
    if (wrEn) mem[addr] <= wrData;
    rdData <= rdEn ? mem[addr] : ~rdData;
  end
endmodule
`default_nettype wire

// File: bench/testbench.sv
/*
 Self-checking bench for carry_sub_alu with a data memory model.
 Assumes the design, its package and the checker are compiled first.
*/
`include "carry_sub_alu_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import carry_sub_alu_pkg::*;
  logic clk_sys = 1'b0, reset_n = 1'b0, cmdValid = 1'b0, cmdReady, cmdDone, memRdEn, memWrEn;
  logic [2:0] cmdOp = 3'h0;
  logic [7:0] cmdAddr = 8'h00, memAddr, memWrData, memRdData, accOut;
  logic zeroFlag, borrowBit, halfBit, rangeFlag, wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, wbAck;
  logic [3:0] wbAdr = 4'h0, wbSel = 4'h0;
  logic [31:0] wbDatI = 32'h0, wbDatO, rd;
  int fails = 0, samples_checked = 0, cycles = 0;

  carry_sub_alu carry_sub_alu_inst (.clk_sys, .reset_n, .cmdValid, .cmdOp, .cmdAddr, .cmdReady,
    .cmdDone, .memRdEn, .memWrEn, .memAddr, .memWrData, .memRdData, .accOut, .zeroFlag,
    .borrowBit, .half_borrow_bit(halfBit), .signed_range_error_flag(rangeFlag),
    .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
    .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck));
  data_mem_model data_mem_model_inst (.clk_sys, .rdEn(memRdEn), .wrEn(memWrEn), .addr(memAddr),
    .wrData(memWrData), .rdData(memRdData));

  always #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fails++;
      report_and_stop();
    end
  end

  // ************************************************************
  // Bus, command and compare tasks
  // ************************************************************
  task automatic report_and_stop();
    if (fails == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chkByte(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: value %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic chkFlags(input logic [3:0] exp);
    chkByte({4'h0, rangeFlag, halfBit, borrowBit, zeroFlag}, {4'h0, exp});
  endtask
  task automatic wbXfer(input logic we, input logic [3:0] adr, input logic [31:0] dat);
    @(posedge clk_sys);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbSel <= 4'hF;
    wbDatI <= dat;
    do @(posedge clk_sys); while (wbAck !== 1'b1);
    rd = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
    wbSel <= 4'h0;
  endtask
  task automatic startOp(input logic [2:0] op, input logic [7:0] a);
    @(posedge clk_sys);
    cmdValid <= 1'b1; cmdOp <= op; cmdAddr <= a;
  endtask
  task automatic finishOp();
    do @(posedge clk_sys); while (cmdReady !== 1'b1);
    cmdValid <= 1'b0;
    do @(negedge clk_sys); while (cmdDone !== 1'b1);
  endtask
  // Loads the operand and flags, runs one op, checks result and flags
  task automatic doOp(input logic [2:0] op, input logic [7:0] a, init, input logic [3:0] fin,
                      input logic [7:0] expV, input logic [3:0] expF);
    if (op == OP_SUBC_ACC) wbXfer(1'b1, `ALU_OFS_ACC, {24'h0, init});
    else data_mem_model_inst.mem[a] = init;
    wbXfer(1'b1, `ALU_OFS_FLAGS, {28'h0, fin});
    startOp(op, a);
    finishOp();
    chkFlags(expF);
    @(negedge clk_sys);
    chkByte(op == OP_SUBC_ACC ? accOut : data_mem_model_inst.mem[a], expV);
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic scenResetRegs();
    wbXfer(1'b0, `ALU_OFS_ACC, 32'h0);
    chkByte(rd[7:0], `RST_ACC);
    wbXfer(1'b0, `ALU_OFS_FLAGS, 32'h0);
    chkByte(rd[7:0], {4'h0, `RST_FLAGS});
    wbXfer(1'b0, `ALU_OFS_STATUS, 32'h0);
    chkByte(rd[15:8], `RST_CNT);
    chkByte(rd[7:0], 8'h00);
    wbXfer(1'b0, `ALU_OFS_CTRL, 32'h0);
    chkByte(rd[7:0], 8'h01);
    wbXfer(1'b0, 4'h2, 32'h0);
    chkByte(rd[7:0], 8'h00);
  endtask
  task automatic scenAccSubc();
    doOp(OP_SUBC_ACC, 8'h00, 8'h00, 4'h2, 8'hFF, 4'h6);
    doOp(OP_SUBC_ACC, 8'h00, 8'h80, 4'h2, 8'h7F, 4'hC);
    doOp(OP_SUBC_ACC, 8'h00, 8'h01, 4'h2, 8'h00, 4'h1);
    doOp(OP_SUBC_ACC, 8'h00, 8'h5A, 4'h0, 8'h5A, 4'h0);
  endtask
  task automatic scenMemOps();
    doOp(OP_SUBC_MEM, 8'h05, 8'h01, 4'h2, 8'h00, 4'h1);
    doOp(OP_SUBC_MEM, 8'hF0, 8'h10, 4'h2, 8'h0F, 4'h4);
    doOp(OP_INC_MEM, 8'h06, 8'hFF, 4'h0, 8'h00, 4'h7);
    doOp(OP_INC_MEM, 8'h07, 8'h7F, 4'h0, 8'h80, 4'hC);
    doOp(OP_DEC_MEM, 8'h08, 8'h00, 4'h0, 8'hFF, 4'h6);
    doOp(OP_DEC_MEM, 8'h09, 8'h80, 4'h0, 8'h7F, 4'hC);
    doOp(OP_CLR_MEM, 8'h0A, 8'hA5, 4'hB, 8'h00, 4'hB);
  endtask
  task automatic scenDisabled();
    wbXfer(1'b0, `ALU_OFS_STATUS, 32'h0);
    chkByte(rd[15:8], 8'h0B);
    chkByte(rd[7:0], 8'h00);
    data_mem_model_inst.mem[11] = 8'h01;
    wbXfer(1'b1, `ALU_OFS_CTRL, 32'h0);
    startOp(OP_DEC_MEM, 8'h0B);
    repeat (4) @(negedge clk_sys);
    chkByte({7'h0, cmdReady}, 8'h00);
    // Request is released at the very edge that takes it after re-enable
    fork
      wbXfer(1'b1, `ALU_OFS_CTRL, 32'h1);
      finishOp();
    join
    chkByte(memWrData, 8'h00);
    chkFlags(4'h1);
  endtask

  initial begin
    repeat (16) @(posedge clk_sys);
    reset_n <= 1'b1;
    scenResetRegs();
    scenAccSubc();
    scenMemOps();
    scenDisabled();
    report_and_stop();
  end
endmodule
`default_nettype wire
